// >>> design/adc_window_detector.sv
// Window detector on the converter result path, with its special-function registers.
`timescale 1ns/1ps
`include "adc_window_defines.svh"
module adc_window_detector
	import adc_window_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic conv_done,
	input wire logic [9:0] conv_data,
	input wire logic diff_mode,
	output logic window_match_flag
);
	limit_if lim ();

	logic flag_r, flag_nxt;
	logic left_align_select_r, left_align_select_nxt;
	logic diff_r, diff_nxt;
	word_t result_r, result_nxt;
	byte_t rdata_r, rdata_nxt;
	word_t result_now;
	logic hit;
	logic ctrl_wr;

	limit_regs u_limits (
		.clk(clk),
		.reset_n(reset_n),
		.lim(lim)
	);

	// Limit writes go straight to the register file.
	assign lim.wr_en = sfr_wr;
	assign lim.addr = sfr_addr;
	assign lim.wdata = sfr_wdata;

	// The window test sees the very word that is stored, so the two never disagree.
	assign result_now = justify(conv_data, left_align_select_r,
		diff_mode);
	assign hit = conv_done && window_hit(result_now,
		lim.gt_word, lim.lt_word, diff_mode);
	assign ctrl_wr = sfr_wr && (sfr_addr == `ADDR_CONTROL);

	// Control bits and the result word; a hit wins over a clearing write in the same cycle.
	always_comb begin
		left_align_select_nxt = left_align_select_r;
		flag_nxt = flag_r;
		result_nxt = result_r;
		diff_nxt = diff_r;
		if (ctrl_wr) begin
			left_align_select_nxt = sfr_wdata[`BIT_LEFT_ALIGN];
			flag_nxt = sfr_wdata[`BIT_WINDOW_FLAG];
		end
		if (hit) begin
			flag_nxt = 1'b1;
		end
		if (conv_done) begin
			result_nxt = result_now;
			diff_nxt = diff_mode;
		end
	end

	// Read data is registered and answers one cycle after the read strobe.
	always_comb begin
		rdata_nxt = rdata_r;
		if (sfr_rd) begin
			case (sfr_addr)
				`ADDR_UPPER_HI: rdata_nxt = lim.gt_word[15:8];
				`ADDR_UPPER_LO: rdata_nxt = lim.gt_word[7:0];
				`ADDR_LOWER_HI: rdata_nxt = lim.lt_word[15:8];
				`ADDR_LOWER_LO: rdata_nxt = lim.lt_word[7:0];
				`ADDR_RESULT_HI: rdata_nxt = result_r[15:8];
				`ADDR_RESULT_LO: rdata_nxt = result_r[7:0];
				`ADDR_CONTROL: rdata_nxt = {6'h00, flag_r, left_align_select_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Registers only.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_r <= 1'b0;
			left_align_select_r <= 1'b0;
			diff_r <= 1'b0;
			result_r <= `RST_RESULT;
			rdata_r <= 8'h00;
		end else begin
			flag_r <= flag_nxt;
			left_align_select_r <= left_align_select_nxt;
			diff_r <= diff_nxt;
			result_r <= result_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata = rdata_r;
	assign window_match_flag = flag_r;

	// A write to a limit byte followed at once by a read of the same byte.
	sequence s_upper_hi_wr_rd;
		sfr_wr && sfr_addr == `ADDR_UPPER_HI && !sfr_rd
			##1 sfr_rd && !sfr_wr && sfr_addr == `ADDR_UPPER_HI;
	endsequence
	sequence s_lower_lo_wr_rd;
		sfr_wr && sfr_addr == `ADDR_LOWER_LO && !sfr_rd
			##1 sfr_rd && !sfr_wr && sfr_addr == `ADDR_LOWER_LO;
	endsequence

	property p_flag_set;
		@(posedge clk) disable iff (!reset_n)
		conv_done && window_hit(result_now, lim.gt_word, lim.lt_word, diff_mode)
			|=> window_match_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("match did not set the flag");

	property p_flag_read;
		@(posedge clk) disable iff (!reset_n)
		sfr_rd && sfr_addr == `ADDR_CONTROL |=> sfr_rdata[1] == $past(window_match_flag);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read back wrong");

	property p_upper_hi;
		@(posedge clk) disable iff (!reset_n)
		s_upper_hi_wr_rd |=> sfr_rdata == $past(sfr_wdata, 2);
	endproperty
	a_upper_hi: assert property (p_upper_hi) else $error("upper high byte lost");

	property p_lower_lo;
		@(posedge clk) disable iff (!reset_n)
		s_lower_lo_wr_rd |=> sfr_rdata == $past(sfr_wdata, 2);
	endproperty
	a_lower_lo: assert property (p_lower_lo) else $error("lower low byte lost");

	property p_inside_miss;
		@(posedge clk) disable iff (!reset_n)
		conv_done && !window_match_flag && !ctrl_wr && below(lim.gt_word, lim.lt_word, diff_mode)
			&& !below(result_now, lim.lt_word, diff_mode) |=> !window_match_flag;
	endproperty
	a_inside_miss: assert property (p_inside_miss)
		else $error("flag set outside window");

	// An outside window never fires on a result equal to either limit.
	property p_outside_equal;
		@(posedge clk) disable iff (!reset_n)
		conv_done && !window_match_flag && !ctrl_wr && !below(lim.gt_word, lim.lt_word, diff_mode)
			&& (result_now == lim.lt_word || result_now == lim.gt_word) |=> !window_match_flag;
	endproperty
	a_outside_equal: assert property (p_outside_equal)
		else $error("equal value set flag");

	// Only a control write may lower the flag, so without one it must still be up next cycle.
	property p_flag_hold;
		@(posedge clk) disable iff (!reset_n)
		window_match_flag && !ctrl_wr |=> window_match_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag cleared by hardware");

	property p_left_low_zero;
		@(posedge clk) disable iff (!reset_n)
		conv_done && left_align_select_r
			|=> result_r[5:0] == 6'h00 && result_r[15:6] == $past(conv_data);
	endproperty
	a_left_low_zero: assert property (p_left_low_zero)
		else $error("left aligned word wrong");

	property p_right_ext;
		@(posedge clk) disable iff (!reset_n)
		conv_done && !left_align_select_r |=>
			result_r[15:10] == {6{diff_r & result_r[9]}} && result_r[9:0] == $past(conv_data);
	endproperty
	a_right_ext: assert property (p_right_ext)
		else $error("right aligned word wrong");

	// Zero lies above an upper limit of minus one only when the compare is signed.
	property p_signed_minus_one;
		@(posedge clk) disable iff (!reset_n)
		conv_done && diff_mode && !left_align_select_r && !ctrl_wr && conv_data == 10'h000
			&& lim.gt_word == 16'hFFFF && lim.lt_word == 16'h0100 |=> window_match_flag;
	endproperty
	a_signed_minus_one: assert property (p_signed_minus_one)
		else $error("signed compare wrong");

	// The flag rises only through a conversion or a control write.
	property p_no_spurious_set;
		@(posedge clk) disable iff (!reset_n)
		!conv_done && !ctrl_wr && !window_match_flag |=> !window_match_flag;
	endproperty
	a_no_spurious_set: assert property (p_no_spurious_set)
		else $error("flag set with no event");

	// A hit in the cycle of a clearing write still leaves the flag set.
	property p_hit_wins;
		@(posedge clk) disable iff (!reset_n)
		conv_done && ctrl_wr && window_hit(result_now, lim.gt_word, lim.lt_word, diff_mode)
			|=> window_match_flag;
	endproperty
	a_hit_wins: assert property (p_hit_wins)
		else $error("clear beat a hit");

	// Writing zero to the flag bit with no conversion in that cycle clears it.
	property p_flag_clear;
		@(posedge clk) disable iff (!reset_n)
		ctrl_wr && !sfr_wdata[`BIT_WINDOW_FLAG] && !conv_done |=> !window_match_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("zero write left flag set");

	// The unused control bits read as zero.
	property p_control_pad;
		@(posedge clk) disable iff (!reset_n)
		sfr_rd && sfr_addr == `ADDR_CONTROL |=> sfr_rdata[7:2] == 6'h00;
	endproperty
	a_control_pad: assert property (p_control_pad)
		else $error("control pad bits not zero");

	// Read data stands until the next read strobe.
	property p_rdata_hold;
		@(posedge clk) disable iff (!reset_n)
		!sfr_rd |=> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without read");

	// The result word changes only at a conversion end.
	property p_result_hold;
		@(posedge clk) disable iff (!reset_n)
		!conv_done |=> $stable(result_r);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("result moved without conversion");

	// A byte write lands in its half of the limit word on the next cycle.
	property p_upper_lo_word;
		@(posedge clk) disable iff (!reset_n)
		sfr_wr && sfr_addr == `ADDR_UPPER_LO |=> lim.gt_word[7:0] == $past(sfr_wdata);
	endproperty
	a_upper_lo_word: assert property (p_upper_lo_word)
		else $error("upper low byte not stored");

	property p_lower_hi_word;
		@(posedge clk) disable iff (!reset_n)
		sfr_wr && sfr_addr == `ADDR_LOWER_HI |=> lim.lt_word[15:8] == $past(sfr_wdata);
	endproperty
	a_lower_hi_word: assert property (p_lower_hi_word)
		else $error("lower high byte not stored");
endmodule

// >>> design/adc_window_defines.svh
// Register addresses, field positions and reset values of the window detector.
`ifndef ADC_WINDOW_DEFINES_SVH
`define ADC_WINDOW_DEFINES_SVH

`define ADDR_UPPER_LO 8'hC4
`define ADDR_UPPER_HI 8'hC5
`define ADDR_LOWER_LO 8'hC6
`define ADDR_LOWER_HI 8'hC7
`define ADDR_CONTROL 8'hE8
`define ADDR_RESULT_HI 8'hBF
`define ADDR_RESULT_LO 8'hBE

`define RST_UPPER_BYTE 8'hFF
`define RST_LOWER_BYTE 8'h00
`define RST_RESULT 16'h0000

`define BIT_LEFT_ALIGN 0
`define BIT_WINDOW_FLAG 1

`endif

// >>> design/adc_window_pkg.sv
// Types and shared arithmetic of the window detector.
package adc_window_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
	typedef logic [9:0] sample_t;

	// Places a 10-bit sample in the 16-bit result word.
	function automatic word_t justify(input sample_t s, input logic left, input logic diff);
		word_t w;
		w = 16'h0000;
		if (left) begin
			w = {s, 6'h00};
		end else begin
			w = {{6{diff & s[9]}}, s};
		end
		return w;
	endfunction

	// Strict less-than, signed for differential pairs and unsigned otherwise.
	function automatic logic below(input word_t a, input word_t b, input logic diff);
		logic r;
		r = 1'b0;
		if (diff) begin
			r = $signed(a) < $signed(b);
		end else begin
			r = a < b;
		end
		return r;
	endfunction

	// Window test: inside when lower exceeds upper, outside otherwise.
	function automatic logic window_hit(input word_t res, input word_t gt, input word_t lt,
		input logic diff);
		logic r;
		r = 1'b0;
		if (below(gt, lt, diff)) begin
			r = below(res, lt, diff) && below(gt, res, diff);
		end else begin
			r = below(res, lt, diff) || below(gt, res, diff);
		end
		return r;
	endfunction

endpackage

// >>> design/limit_if.sv
// Link between the bus decoder and the limit register file.
`timescale 1ns/1ps
interface limit_if;
	import adc_window_pkg::*;
	logic wr_en;
	byte_t addr;
	byte_t wdata;
	word_t gt_word;
	word_t lt_word;
	modport regs (input wr_en, input addr, input wdata, output gt_word, output lt_word);
	modport user (output wr_en, output addr, output wdata, input gt_word, input lt_word);
endinterface

// >>> design/limit_regs.sv
// The four byte-wide limit registers.
`timescale 1ns/1ps
`include "adc_window_defines.svh"
module limit_regs
	import adc_window_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	limit_if.regs lim
);
	byte_t upper_limit_high_byte_r, upper_limit_high_byte_nxt;
	byte_t upper_limit_low_byte_r, upper_limit_low_byte_nxt;
	byte_t lower_limit_high_byte_r, lower_limit_high_byte_nxt;
	byte_t lower_limit_low_byte_r, lower_limit_low_byte_nxt;

	// Each byte is written alone, so the window test sees torn words while software reloads.
	always_comb begin
		upper_limit_high_byte_nxt = upper_limit_high_byte_r;
		upper_limit_low_byte_nxt = upper_limit_low_byte_r;
		lower_limit_high_byte_nxt = lower_limit_high_byte_r;
		lower_limit_low_byte_nxt = lower_limit_low_byte_r;
		if (lim.wr_en) begin
			case (lim.addr)
				`ADDR_UPPER_HI: upper_limit_high_byte_nxt = lim.wdata;
				`ADDR_UPPER_LO: upper_limit_low_byte_nxt = lim.wdata;
				`ADDR_LOWER_HI: lower_limit_high_byte_nxt = lim.wdata;
				`ADDR_LOWER_LO: lower_limit_low_byte_nxt = lim.wdata;
				default: ;
			endcase
		end
	end

	// Registers only.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_limit_high_byte_r <= `RST_UPPER_BYTE;
			upper_limit_low_byte_r <= `RST_UPPER_BYTE;
			lower_limit_high_byte_r <= `RST_LOWER_BYTE;
			lower_limit_low_byte_r <= `RST_LOWER_BYTE;
		end else begin
			upper_limit_high_byte_r <= upper_limit_high_byte_nxt;
			upper_limit_low_byte_r <= upper_limit_low_byte_nxt;
			lower_limit_high_byte_r <= lower_limit_high_byte_nxt;
			lower_limit_low_byte_r <= lower_limit_low_byte_nxt;
		end
	end

	// Words are high byte above low byte.
	assign lim.gt_word = {upper_limit_high_byte_r, upper_limit_low_byte_r};
	assign lim.lt_word = {lower_limit_high_byte_r, lower_limit_low_byte_r};
endmodule

// >>> sim/cpu_model.sv
// Processor-side model that drives the special-function register strobes.
`timescale 1ns/1ps
module cpu_model (
	input wire logic clk,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	output logic sfr_wr,
	output logic sfr_rd,
	input wire logic [7:0] sfr_rdata
);
	// Strobes idle low from time zero.
	initial begin
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end

	// Write data flips after the strobe so a stale byte cannot pass for a good one.
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
	endtask

	// Read data is taken once the strobe edge has registered it.
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	// Software clears the sticky match flag by writing it to zero, keeping the align bit.
	task automatic clear_flag(input logic al);
		sfr_write(8'hE8, {7'h00, al});
	endtask

	// Write then read the same byte on the very next edge, as tight code would.
	task automatic sfr_write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		q = sfr_rdata;
	endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the window detector.
`timescale 1ns/1ps
module testbench;
	import adc_window_pkg::*;
	logic clk;
	logic reset_n;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic sfr_wr;
	logic sfr_rd;
	logic [7:0] sfr_rdata;
	logic conv_done;
	logic [9:0] conv_data;
	logic diff_mode;
	logic window_match_flag;
	int n_errors;
	int n_compared;
	byte_t rd_v;

	adc_window_detector adc_window_detector_inst (.clk(clk), .reset_n(reset_n),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_rdata(sfr_rdata), .conv_done(conv_done), .conv_data(conv_data),
		.diff_mode(diff_mode), .window_match_flag(window_match_flag));
	cpu_model cpu_model_inst (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));

	// A 5 ns period gives the 200 MHz system clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rdchk(input byte_t a, input byte_t exp);
		cpu_model_inst.sfr_read(a, rd_v);
		chk({8'h00, rd_v}, {8'h00, exp});
	endtask

	// Loads both limits byte by byte and reads every byte back.
	task automatic setlim(input word_t gt, input word_t lt);
		byte_t v[4];
		v = '{gt[7:0], gt[15:8], lt[7:0], lt[15:8]};
		for (int i = 0; i < 4; i++) cpu_model_inst.sfr_write(byte_t'(8'hC4 + i), v[i]);
		for (int i = 0; i < 4; i++) rdchk(byte_t'(8'hC4 + i), v[i]);
	endtask

	// One conversion; the flag must hold through a control read, then clear on a zero write.
	task automatic conv(input sample_t d, input logic df, input logic exp, input logic al);
		@(posedge clk);
		#1;
		conv_done = 1'b1;
		conv_data = d;
		diff_mode = df;
		@(posedge clk);
		#1;
		conv_done = 1'b0;
		conv_data = ~d;
		chk({15'h0000, window_match_flag}, {15'h0000, exp});
		rdchk(8'hE8, {6'h00, exp, al});
		cpu_model_inst.clear_flag(al);
		chk({15'h0000, window_match_flag}, 16'h0000);
	endtask

	// Every limit register and the control register must come out of reset at its documented value.
	task automatic t_reset();
		rdchk(8'hC4, 8'hFF);
		rdchk(8'hC5, 8'hFF);
		rdchk(8'hC6, 8'h00);
		rdchk(8'hC7, 8'h00);
		rdchk(8'hE8, 8'h00);
		rdchk(8'h00, 8'h00);
		$display("test reset done");
	endtask

	// Edges of both windows must not set the flag; strictly inside or outside must.
	task automatic t_right();
		setlim(16'h0100, 16'h0200);
		conv(10'h200, 1'b0, 1'b0, 1'b0);
		conv(10'h100, 1'b0, 1'b0, 1'b0);
		conv(10'h1FF, 1'b0, 1'b1, 1'b0);
		conv(10'h101, 1'b0, 1'b1, 1'b0);
		setlim(16'h0200, 16'h0100);
		conv(10'h100, 1'b0, 1'b0, 1'b0);
		conv(10'h200, 1'b0, 1'b0, 1'b0);
		conv(10'h0FF, 1'b0, 1'b1, 1'b0);
		conv(10'h201, 1'b0, 1'b1, 1'b0);
		rdchk(8'hBF, 8'h02);
		rdchk(8'hBE, 8'h01);
		$display("test right aligned done");
	endtask

	// Signed compare in differential mode; the same limits read unsigned leave 0x03FF alone.
	task automatic t_diff();
		setlim(16'hFFFF, 16'h0100);
		conv(10'h3FF, 1'b1, 1'b0, 1'b0);
		rdchk(8'hBF, 8'hFF);
		rdchk(8'hBE, 8'hFF);
		conv(10'h000, 1'b1, 1'b1, 1'b0);
		conv(10'h200, 1'b1, 1'b0, 1'b0);
		rdchk(8'hBF, 8'hFE);
		conv(10'h3FF, 1'b0, 1'b0, 1'b0);
		rdchk(8'hBF, 8'h03);
		$display("test differential done");
	endtask

	// Left aligned words against limits written in the same alignment.
	task automatic t_left();
		cpu_model_inst.sfr_write(8'hE8, 8'h01);
		setlim(16'h4000, 16'h8000);
		conv(10'h200, 1'b0, 1'b0, 1'b1);
		conv(10'h100, 1'b0, 1'b0, 1'b1);
		conv(10'h1FF, 1'b0, 1'b1, 1'b1);
		rdchk(8'hBF, 8'h7F);
		rdchk(8'hBE, 8'hC0);
		conv(10'h200, 1'b1, 1'b0, 1'b1);
		rdchk(8'hBF, 8'h80);
		rdchk(8'hBE, 8'h00);
		$display("test left aligned done");
	endtask

	// A hit and a clearing write in one cycle leave the flag set; then tight write-read pairs.
	task automatic t_b2b();
		fork
			cpu_model_inst.clear_flag(1'b1);
			begin
				@(posedge clk);
				#1;
				conv_done = 1'b1;
				conv_data = 10'h1FF;
				diff_mode = 1'b0;
				@(posedge clk);
				#1;
				conv_done = 1'b0;
			end
		join
		chk({15'h0000, window_match_flag}, 16'h0001);
		cpu_model_inst.clear_flag(1'b1);
		chk({15'h0000, window_match_flag}, 16'h0000);
		cpu_model_inst.sfr_write_read(8'hC5, 8'h5A, rd_v);
		chk({8'h00, rd_v}, 16'h005A);
		cpu_model_inst.sfr_write_read(8'hC6, 8'hA5, rd_v);
		chk({8'h00, rd_v}, 16'h00A5);
		$display("test back to back done");
	endtask

	// Inputs settle at time zero; reset holds for ten cycles.
	initial begin
		n_errors = 0;
		n_compared = 0;
		reset_n = 1'b0;
		conv_done = 1'b0;
		conv_data = 10'h000;
		diff_mode = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		reset_n = 1'b1;
		t_reset();
		t_right();
		t_diff();
		t_left();
		t_b2b();
		test_done();
	end

	// The tests need about two hundred cycles; this limit leaves a wide margin.
	initial begin
		#100000;
		n_errors++;
		test_done();
	end
endmodule
